//--- rtl/gudc_defines.svh
`ifndef GUDC_DEFINES_SVH
`define GUDC_DEFINES_SVH

// Register byte offsets on the Avalon slave
`define GUDC_OFS_CTRL 8'h00
`define GUDC_OFS_TIMEBASE 8'h04
`define GUDC_OFS_CMD 8'h08
`define GUDC_OFS_COUNT 8'h0C
`define GUDC_OFS_STATUS 8'h10

// Control register fields
`define GUDC_CTRL_GATE_MODE 0
`define GUDC_CTRL_DIR_SRC 1
`define GUDC_CTRL_DIR_SW 2

// Command register fields, write-one pulses
`define GUDC_CMD_START 0
`define GUDC_CMD_STOP 1
`define GUDC_CMD_CLEAR 2

// Status register fields
`define GUDC_STAT_RUN 0
`define GUDC_STAT_UP 1
`define GUDC_STAT_GATE 2
`define GUDC_STAT_INTERNAL 3

// Reset values
`define GUDC_RST_CTRL 3'h0
`define GUDC_RST_TIMEBASE 32'h00000000
`define GUDC_RST_COUNT 32'h00000000

// System clock rate in Hz, 250 MHz
`define GUDC_CLK_HZ 32'h0EE6B280

`endif

//--- rtl/gudc_pkg.sv
package gudc_pkg;

  // Configuration held in the control register
  typedef struct packed {
    logic dir_sw;     // Software direction, 1 is up
    logic dir_src;    // Direction source, 1 is pin
    logic gate_mode;  // 1 gates counting with pin
  } gudc_cfg_t;

  // The three external counter pins
  typedef struct packed {
    logic dir;   // External direction level
    logic gate;  // External gate level
    logic src;   // External count source
  } gudc_pins_t;

  // Run state of the counter
  typedef enum logic {
    GUDC_IDLE,
    GUDC_RUN
  } gudc_run_t;

  // Whole state of the counter core
  typedef struct packed {
    gudc_run_t run;
    gudc_cfg_t cfg;
    logic [31:0] timebase;
    logic [31:0] acc;
    logic [31:0] count;
    logic ack;
    logic [31:0] rdata;
  } gudc_state_t;

  // Whole state of the pin synchroniser
  typedef struct packed {
    gudc_pins_t meta;
    gudc_pins_t stable;
    logic src_prev;
  } gudc_sync_t;

endpackage

//--- rtl/gudc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module gudc_pin_sync import gudc_pkg::*; (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Raw pins
  input wire gudc_pins_t i_pins,
  // Synchronised levels and source edge
  output gudc_pins_t o_lvl,
  output logic o_src_rise
);

  gudc_sync_t s;       // Registered state
  gudc_sync_t next_s;  // Next state

  // Two flops per pin; first stage feeds only the second
  always_comb begin
    next_s = s;
    next_s.meta = i_pins;
    next_s.stable = s.meta;
    next_s.src_prev = s.stable.src;
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Edge taken from settled stages only
  assign o_lvl = s.stable;
  assign o_src_rise = s.stable.src & ~s.src_prev;

endmodule
`default_nettype wire

//--- rtl/gudc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "gudc_defines.svh"
module gudc_top import gudc_pkg::*; (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // External counter pins
  input wire logic i_count_source,
  input wire logic i_count_gate,
  input wire logic i_count_direction_input,
  // Status
  output logic o_running
);

  // Register select codes
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_CTRL = 3'h1;
  localparam logic [2:0] SEL_TB = 3'h2;
  localparam logic [2:0] SEL_CMD = 3'h3;
  localparam logic [2:0] SEL_COUNT = 3'h4;
  localparam logic [2:0] SEL_STAT = 3'h5;
  localparam logic [32:0] CLK_HZ_W = {1'b0, `GUDC_CLK_HZ};

  gudc_state_t s;       // Registered state
  gudc_state_t next_s;  // Next state
  gudc_pins_t raw;      // Pins gathered for syncing
  gudc_pins_t lvl;      // Synchronised pin levels
  logic src_rise;       // Synchronised source edge
  logic req;            // Bus request present
  logic take;           // Bus access completes
  logic [2:0] sel;      // Decoded register
  logic tb_use;         // Internal timebase chosen
  logic [31:0] tb_inc;  // Clamped timebase step
  logic [32:0] acc_sum; // Accumulator plus step
  logic tick;           // Internal timebase event
  logic event_in;       // Selected count event
  logic enabled;        // Counting allowed now
  logic up;             // Effective direction

  // Address decode, used for read and write
  function automatic logic [2:0] decode(input logic [7:0] addr);
    logic [2:0] r;
    r = SEL_NONE;
    if (addr == `GUDC_OFS_CTRL) begin
      r = SEL_CTRL;
    end else if (addr == `GUDC_OFS_TIMEBASE) begin
      r = SEL_TB;
    end else if (addr == `GUDC_OFS_CMD) begin
      r = SEL_CMD;
    end else if (addr == `GUDC_OFS_COUNT) begin
      r = SEL_COUNT;
    end else if (addr == `GUDC_OFS_STATUS) begin
      r = SEL_STAT;
    end
    return r;
  endfunction

  // Byte lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Pins cross into the clock domain here
  // Edge taken after the second flop, so a pin edge reaches the count
  // three clocks late; pulses shorter than one clock may be missed
  assign raw.src = i_count_source;
  assign raw.gate = i_count_gate;
  assign raw.dir = i_count_direction_input;

  gudc_pin_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pins(raw),
    .o_lvl(lvl),
    .o_src_rise(src_rise)
  );

  // Bus handshake: one wait cycle, then done
  // Waitrequest is combinational so the first cycle of a request stalls;
  // the registered ack releases it, costing two cycles per access
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~s.ack;
  assign take = req & s.ack;
  assign sel = decode(i_avs_address);

  // Timebase, event and direction selection
  // Accumulator adds the rate each clock and ticks on reaching the clock
  // rate, so slow rates spread their ticks evenly with no divider table
  always_comb begin
    // Positive signed value means internal timebase
    tb_use = ($signed(s.timebase) > 32'sh00000000);
    // Faster than the clock cannot tick more than once a cycle
    if (s.timebase > `GUDC_CLK_HZ) begin
      tb_inc = `GUDC_CLK_HZ;
    end else begin
      tb_inc = s.timebase;
    end
    acc_sum = {1'b0, s.acc} + {1'b0, tb_inc};
    tick = tb_use && (acc_sum >= CLK_HZ_W);
    // Internal ticks or external rising edges
    event_in = tb_use ? tick : src_rise;
    // Gate ignored in mode 0, required in mode 1
    enabled = (s.run == GUDC_RUN) && (!s.cfg.gate_mode || lvl.gate);
    // Pin or software direction
    up = s.cfg.dir_src ? lvl.dir : s.cfg.dir_sw;
  end

  // Next state of the whole counter
  // Later assignments win: an event is overridden by a software load or
  // clear in the same cycle, so software always sees what it wrote
  always_comb begin
    next_s = s;
    // Ack raised for one cycle after a request arrives
    next_s.ack = req & ~s.ack;

    // Fractional accumulator for the timebase
    if (!tb_use) begin
      next_s.acc = 32'h00000000;
    end else if (tick) begin
      next_s.acc = 32'(acc_sum - CLK_HZ_W);
    end else begin
      next_s.acc = acc_sum[31:0];
    end

    // Direction sampled at the event itself
    if (event_in && enabled) begin
      if (up) begin
        next_s.count = s.count + 32'h00000001;
      end else begin
        next_s.count = s.count - 32'h00000001;
      end
    end

    // Capturing in the wait cycle keeps read data on a flop, at the
    // price of a fixed one-cycle stall on every read
    // Read data captured in the waiting cycle
    if (i_avs_read && !s.ack) begin
      if (sel == SEL_CTRL) begin
        next_s.rdata = {29'h0000000, s.cfg};
      end else if (sel == SEL_TB) begin
        next_s.rdata = s.timebase;
      end else if (sel == SEL_COUNT) begin
        next_s.rdata = s.count;
      end else if (sel == SEL_STAT) begin
        next_s.rdata = {28'h0000000, tb_use, lvl.gate, up,
                        s.run == GUDC_RUN};
      end else begin
        // Command and unmapped addresses read zero
        next_s.rdata = 32'h00000000;
      end
    end

    // Writes land on the completing edge
    if (take && i_avs_write) begin
      if (sel == SEL_CTRL) begin
        next_s.cfg = gudc_cfg_t'(3'(merge({29'h0000000, s.cfg},
                                          i_avs_writedata,
                                          i_avs_byteenable)));
      end else if (sel == SEL_TB) begin
        next_s.timebase = merge(s.timebase, i_avs_writedata,
                                i_avs_byteenable);
        // Restart the phase so the new rate begins cleanly
        next_s.acc = 32'h00000000;
      end else if (sel == SEL_CMD && i_avs_byteenable[0]) begin
        // Stop beats start when both are written
        if (i_avs_writedata[`GUDC_CMD_STOP]) begin
          next_s.run = GUDC_IDLE;
        end else if (i_avs_writedata[`GUDC_CMD_START]) begin
          next_s.run = GUDC_RUN;
        end
        // Clear overrides an event in the same cycle
        if (i_avs_writedata[`GUDC_CMD_CLEAR]) begin
          next_s.count = `GUDC_RST_COUNT;
        end
      end else if (sel == SEL_COUNT) begin
        // Software load wins over a simultaneous event
        next_s.count = merge(s.count, i_avs_writedata,
                             i_avs_byteenable);
      end
    end
  end

  // State register
  // Synchronous reset puts every field back to its idle value
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s.run <= GUDC_IDLE;
      s.cfg <= gudc_cfg_t'(`GUDC_RST_CTRL);
      s.timebase <= `GUDC_RST_TIMEBASE;
      s.acc <= 32'h00000000;
      s.count <= `GUDC_RST_COUNT;
      s.ack <= 1'b0;
      s.rdata <= 32'h00000000;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign o_avs_readdata = s.rdata;
  assign o_running = (s.run == GUDC_RUN);

endmodule
`default_nettype wire

//--- dv/gudc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module gudc_sva (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Bus and status
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_running
);
  // Command write completing this cycle
  logic cmd_go;
  assign cmd_go = i_avs_write && !o_avs_waitrequest &&
                  i_avs_address == 8'h08 && i_avs_byteenable[0];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_wait;
    $rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait)
    else $error("read wait cycle wrong");
  property p_idle;
    o_avs_waitrequest |-> i_avs_read || i_avs_write;
  endproperty
  a_idle: assert property (p_idle)
    else $error("wait without request");
  property p_one;
    o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_one: assert property (p_one)
    else $error("more than one wait cycle");
  property p_start;
    cmd_go && i_avs_writedata[1:0] == 2'h1 |=> o_running;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not run");
  property p_stop;
    cmd_go && i_avs_writedata[1] |=> !o_running;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not halt");
  property p_run;
    $changed(o_running) |-> $past(cmd_go);
  endproperty
  a_run: assert property (p_run)
    else $error("run changed without command");
  property p_hold;
    $changed(o_avs_readdata) |-> $past(i_avs_read && o_avs_waitrequest);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved");
  property p_zero;
    i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h14
      |-> o_avs_readdata == 32'h0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("unmapped read not zero");
endmodule
bind gudc_top gudc_sva u_gudc_sva (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_running(o_running));
`default_nettype wire

//--- dv/gudc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module gudc_pin_model (
  // Clock
  input wire logic i_clk_sys,
  // Pins toward the counter
  output logic o_src,
  output logic o_gate,
  output logic o_dir
);
  // Source rests low between bursts
  initial begin
    o_src = 1'b0;
    o_gate = 1'b0;
    o_dir = 1'b0;
  end
  // Three clocks high, four low between pulses, safely above the sync minimum
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      o_src <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      o_src <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
    end
  endtask
  // Levels settle through the sync before returning
  task automatic levels(input logic g, input logic d);
    @(posedge i_clk_sys);
    o_gate <= g;
    o_dir <= d;
    repeat (6) @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

//--- dv/gudc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module gudc_top_test;
  // Bench signals
  logic clk, rst, rd_en, wr_en, wreq, run, src, gate, dir;
  logic [7:0] adr;
  logic [3:0] be;
  logic [31:0] wd, rdat, v, a;
  int err_total, samples_checked;
  gudc_top u_gudc_top (.i_clk_sys(clk), .i_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wd),
    .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_count_source(src), .i_count_gate(gate),
    .i_count_direction_input(dir), .o_running(run));
  gudc_pin_model u_gudc_pin_model (.i_clk_sys(clk), .o_src(src),
    .o_gate(gate), .o_dir(dir));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One access; waits on waitrequest, result in v
  task automatic bus(input logic w, input logic [7:0] ad, input int d);
    @(posedge clk);
    adr <= ad;
    wd <= d;
    wr_en <= w;
    rd_en <= !w;
    // Request stands until waitrequest is seen low at a rising edge
    do @(posedge clk); while (wreq !== 1'b0);
    v = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  // Let pin latency pass, then read the count
  task automatic cnt(input int e);
    repeat (8) @(posedge clk);
    bus(1'b0, 8'h0C, 0);
    chk(v, e);
  endtask
  task automatic t_map;
    chk(32'(run), 0);
    bus(1'b1, 8'h14, 7);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 8'(i * 4), 0);
      chk(v, 0);
    end
    be <= 4'h1;
    bus(1'b1, 8'h0C, 32'hAABBCC55);
    be <= 4'hE;
    bus(1'b1, 8'h08, 1);
    bus(1'b0, 8'h0C, 0);
    chk(v, 32'h00000055);
    chk(32'(run), 0);
    be <= 4'hF;
  endtask
  task automatic t_dir;
    bus(1'b1, 8'h0C, 10);
    bus(1'b1, 8'h08, 1);
    u_gudc_pin_model.pulses(3);
    cnt(7);
    bus(1'b1, 8'h00, 4);
    u_gudc_pin_model.pulses(2);
    cnt(9);
    bus(1'b1, 8'h00, 2);
    u_gudc_pin_model.levels(1'b0, 1'b1);
    bus(1'b0, 8'h10, 0);
    chk(v, 32'h00000003);
    u_gudc_pin_model.pulses(1);
    cnt(10);
    u_gudc_pin_model.levels(1'b0, 1'b0);
    u_gudc_pin_model.pulses(2);
    cnt(8);
  endtask
  task automatic t_gate;
    bus(1'b1, 8'h08, 3);
    @(posedge clk);
    chk(32'(run), 0);
    bus(1'b1, 8'h00, 1);
    bus(1'b1, 8'h0C, 5);
    u_gudc_pin_model.levels(1'b1, 1'b0);
    u_gudc_pin_model.pulses(1);
    cnt(5);
    bus(1'b1, 8'h08, 1);
    @(posedge clk);
    chk(32'(run), 1);
    u_gudc_pin_model.levels(1'b0, 1'b0);
    u_gudc_pin_model.pulses(2);
    cnt(5);
    u_gudc_pin_model.levels(1'b1, 1'b0);
    u_gudc_pin_model.pulses(2);
    cnt(3);
  endtask
  // Full-rate timebase ticks once per clock
  task automatic t_tb;
    bus(1'b1, 8'h00, 4);
    bus(1'b1, 8'h04, 32'h0EE6B280);
    bus(1'b0, 8'h0C, 0);
    a = v;
    bus(1'b0, 8'h0C, 0);
    chk(v - a, 3);
    bus(1'b0, 8'h10, 0);
    chk(v, 32'h0000000F);
    bus(1'b1, 8'h04, -1);
    bus(1'b1, 8'h0C, 0);
    u_gudc_pin_model.pulses(2);
    cnt(2);
  endtask
  task automatic results;
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results;
  end
  initial begin
    {rst, rd_en, wr_en, adr, wd} = {1'b1, 42'h0};
    be = 4'hF;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_map;
    t_dir;
    t_gate;
    t_tb;
    results;
  end
endmodule
`default_nettype wire
